/* verilog/sipo_cfg.svh */
// constants for the gated serial-in parallel-out shifter
`ifndef SIPO_CFG_SVH
`define SIPO_CFG_SVH
`define SIPO_STAGES 8
`define SIPO_STAGE_RST 8'h00
`define SIPO_BUF_DEPTH 2
`endif

/* verilog/sipo_pkg.sv */
// types shared by the output buffer and the test bench
`include "sipo_cfg.svh"
package sipo_pkg;
    typedef logic [`SIPO_STAGES-1:0] stage_word_t;
    // buffer occupancy, gray coded along empty -> one -> full
    typedef enum logic [1:0] {
        BUF_EMPTY = 2'h0,
        BUF_ONE = 2'h1,
        BUF_FULL = 2'h3
    } buf_state_t;
endpackage

/* verilog/pair_buffer.sv */
// two-entry valid/ready buffer for captured parallel words
`timescale 1ns/100ps
`include "sipo_cfg.svh"
module pair_buffer #(
    parameter int WIDTH = `SIPO_STAGES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_reg [0:1];
    logic [WIDTH-1:0] mem_next [0:1];
    logic wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    sipo_pkg::buf_state_t state_reg, state_next;
    logic push, pop;

    // handshake and data views of the occupancy
    assign in_ready = (state_reg != sipo_pkg::BUF_FULL);
    assign out_valid = (state_reg != sipo_pkg::BUF_EMPTY);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    ////////////////////////////////////////////////////////////////////////
    // next occupancy, pointers and slot contents
    always_comb begin
        mem_next[0] = mem_reg[0];
        mem_next[1] = mem_reg[1];
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        state_next = state_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = in_data;
            wr_ptr_next = ~wr_ptr_reg;
        end
        if (pop) begin
            rd_ptr_next = ~rd_ptr_reg;
        end
        case (state_reg)
            sipo_pkg::BUF_EMPTY: begin
                if (push) state_next = sipo_pkg::BUF_ONE;
            end
            sipo_pkg::BUF_ONE: begin
                if (push && !pop) state_next = sipo_pkg::BUF_FULL;
                else if (pop && !push) state_next = sipo_pkg::BUF_EMPTY;
            end
            sipo_pkg::BUF_FULL: begin
                if (pop) state_next = sipo_pkg::BUF_ONE;
            end
            default: state_next = sipo_pkg::BUF_EMPTY;
        endcase
    end

    // register stage
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            state_reg <= sipo_pkg::BUF_EMPTY;
        end else begin
            mem_reg[0] <= mem_next[0];
            mem_reg[1] <= mem_next[1];
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            state_reg <= state_next;
        end
    end

    default clocking buf_cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    stalled_word_holds_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("buffered word changed while stalled");
    full_refuses_a: assert property (state_reg == sipo_pkg::BUF_FULL |-> !in_ready)
        else $error("buffer full but still ready");
endmodule

/* verilog/gated_sipo_shifter.sv */
// eight-stage gated serial-in parallel-out shifter with word buffer
// Behaviour
// R1 - eight stages, each shown as parallel output
// R2 - first stage loads AND of serial inputs
// R3 - any low gate input loads a low
// R4 - one input high, other alone decides
// R5 - stages change only on shift clock rise
// R6 - each later stage takes its predecessor's value
// R7 - no rising edge means stages hold
// R8 - low clear forces all stages low immediately
// R9 - serial inputs may change any time between edges
// R10 - first rise after clear shifts normally
`timescale 1ns/100ps
`include "sipo_cfg.svh"
module gated_sipo_shifter #(
    parameter int STAGES = `SIPO_STAGES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic async_clear_n,
    input wire logic shift_clk,
    input wire logic ser_a,
    input wire logic ser_b,
    output logic [STAGES-1:0] stage_q,
    output logic capture_ready,
    output logic word_valid,
    input wire logic word_ready,
    output logic [STAGES-1:0] word_data
);
    logic [STAGES-1:0] stage_reg, stage_next;
    logic shift_prev_reg, shift_prev_next;
    logic shift_rise;
    logic gated_bit;
    logic stage_clr_n;

    ////////////////////////////////////////////////////////////////////////
    // edge detect and gated serial bit
    assign shift_rise = shift_clk & ~shift_prev_reg; // R5
    assign gated_bit = ser_a & ser_b; // R2 R3 R4
    assign stage_clr_n = rst_n & async_clear_n; // R8
    assign stage_q = stage_reg; // R1

    // shift on a rising edge, otherwise hold
    always_comb begin
        shift_prev_next = shift_clk;
        stage_next = stage_reg; // R7 R9
        if (shift_rise) begin
            stage_next = {stage_reg[STAGES-2:0], gated_bit}; // R6 R2
        end
    end

    // stages cleared asynchronously by either clear or reset
    always_ff @(posedge mclk or negedge stage_clr_n) begin
        if (!stage_clr_n) begin
            stage_reg <= `SIPO_STAGE_RST; // R8
        end else begin
            stage_reg <= stage_next; // R10
        end
    end

    // edge history survives clear so shifting resumes at once
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_prev_reg <= 1'b0;
        end else begin
            shift_prev_reg <= shift_prev_next; // R10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // each shifted word is offered to the two-entry buffer
    pair_buffer #(
        .WIDTH(STAGES)
    ) word_buf (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(shift_rise & async_clear_n),
        .in_data(stage_next),
        .in_ready(capture_ready),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence clear_held;
        !async_clear_n;
    endsequence

    sequence release_then_rise;
        clear_held ##1 (async_clear_n && shift_rise);
    endsequence

    first_stage_and_a: assert property (@(posedge mclk) disable iff (!stage_clr_n)
        shift_rise |=> stage_reg[0] == $past(ser_a & ser_b)) // R2
        else $error("first stage not AND of serial inputs");
    gate_blocks_a: assert property (@(posedge mclk) disable iff (!stage_clr_n)
        shift_rise && (!ser_a || !ser_b) |=> !stage_reg[0]) // R3
        else $error("low gate input did not block data");
    gate_passes_a: assert property (@(posedge mclk) disable iff (!stage_clr_n)
        shift_rise && ser_a |=> stage_reg[0] == $past(ser_b)) // R4
        else $error("enabled input did not decide first stage");
    shift_chain_a: assert property (@(posedge mclk) disable iff (!stage_clr_n)
        shift_rise |=> stage_reg[STAGES-1:1] == $past(stage_reg[STAGES-2:0])) // R6
        else $error("stages did not shift by one");
    hold_no_edge_a: assert property (@(posedge mclk) disable iff (!stage_clr_n)
        !shift_rise ##1 async_clear_n |-> $stable(stage_reg)) // R7
        else $error("stages changed without rising edge");
    inputs_ignored_a: assert property (@(posedge mclk) disable iff (!stage_clr_n)
        !shift_rise && $changed(ser_a) |=> stage_reg[0] == $past(stage_reg[0])) // R9
        else $error("serial change between edges altered stage");
    rise_only_a: assert property (@(posedge mclk) disable iff (!stage_clr_n)
        !shift_clk || shift_prev_reg |=> $stable(stage_q)) // R5
        else $error("stages updated without rising edge");
    clear_forces_a: assert property (@(posedge mclk) disable iff (!rst_n)
        clear_held |-> stage_q == `SIPO_STAGE_RST) // R8
        else $error("clear did not force stages low");
    resume_shift_a: assert property (@(posedge mclk) disable iff (!rst_n)
        release_then_rise |=> stage_reg == {{(STAGES-1){1'b0}}, $past(gated_bit)}) // R10
        else $error("first edge after clear did not shift");
    parallel_view_a: assert property (@(posedge mclk) disable iff (!stage_clr_n)
        shift_rise && async_clear_n && !word_valid |=> word_valid && word_data == stage_q) // R1
        else $error("captured word not offered");
endmodule

/* test/upstream_model.sv */
// upstream logic model driving shift clock, serial inputs and clear
`timescale 1ns/100ps
module upstream_model (
    input wire logic mclk,
    output logic shift_clk,
    output logic ser_a,
    output logic ser_b,
    output logic async_clear_n
);
    initial begin
        shift_clk = 1'b0;
        ser_a = 1'b0;
        ser_b = 1'b0;
        async_clear_n = 1'b1;
    end
    // one shift clock pulse, held for one mclk sample, idle low otherwise
    task automatic shift(input logic a, input logic b);
        @(posedge mclk);
        shift_clk <= 1'b1;
        ser_a <= a;
        ser_b <= b;
        @(posedge mclk);
        shift_clk <= 1'b0;
        // serial lines wander once the edge has passed
        ser_a <= ~a;
        ser_b <= ~b;
    endtask
    // clear level, changed just after a rising edge
    task automatic set_clear(input logic v);
        @(posedge mclk);
        async_clear_n <= v;
    endtask
endmodule

/* test/tb.sv */
// self-checking bench for the gated shifter and its word buffer
`timescale 1ns/100ps
module tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic word_ready = 1'b1;
    logic shift_clk, ser_a, ser_b, async_clear_n, capture_ready, word_valid;
    sipo_pkg::stage_word_t stage_q, word_data, exp;
    int fail_count = 0;
    int samples_checked = 0;
    // rows: ser_a, ser_b, expected first stage
    logic [2:0] rows [6] = '{3'h7, 3'h2, 3'h4, 3'h7, 3'h0, 3'h7};
    always #50 mclk = ~mclk;
    upstream_model upstream_model_i (.mclk(mclk), .shift_clk(shift_clk), .ser_a(ser_a), .ser_b(ser_b),
        .async_clear_n(async_clear_n));
    gated_sipo_shifter gated_sipo_shifter_i (.mclk(mclk), .rst_n(rst_n), .async_clear_n(async_clear_n),
        .shift_clk(shift_clk), .ser_a(ser_a), .ser_b(ser_b), .stage_q(stage_q), .capture_ready(capture_ready),
        .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));
    task automatic cmp(input logic [7:0] got, input logic [7:0] want, input string what);
        samples_checked++;
        if (got !== want) begin
            fail_count++;
            $display("CHECK FAILED %0t %s got %h want %h", $time, what, got, want);
        end
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // take one buffered word after checking it
    task automatic pop(input logic [7:0] want);
        cmp({7'h00, word_valid}, 8'h01, "word valid");
        cmp(word_data, want, "word data");
        @(posedge mclk);
        word_ready <= 1'b1;
        @(posedge mclk);
        word_ready <= 1'b0;
        #1;
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        $display("CHECK FAILED %0t run did not finish", $time);
        final_report();
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        cmp(stage_q, 8'h00, "reset stages");
        cmp({7'h00, capture_ready}, 8'h01, "reset ready");
        exp = 8'h00;
        foreach (rows[i]) begin
            upstream_model_i.shift(rows[i][2], rows[i][1]);
            #1;
            exp = {exp[6:0], rows[i][0]};
            cmp(stage_q, exp, "shift row");
        end
        $display("test rows done");
        repeat (3) @(posedge mclk);
        #1;
        cmp(stage_q, exp, "hold");
        $display("test hold done");
        upstream_model_i.set_clear(1'b0);
        #1;
        cmp(stage_q, 8'h00, "clear now");
        upstream_model_i.shift(1'b1, 1'b1);
        #1;
        cmp(stage_q, 8'h00, "clear holds");
        upstream_model_i.set_clear(1'b1);
        upstream_model_i.shift(1'b1, 1'b1);
        #1;
        cmp(stage_q, 8'h01, "first shift after clear");
        $display("test clear done");
        repeat (2) @(posedge mclk);
        word_ready <= 1'b0;
        upstream_model_i.shift(1'b1, 1'b1);
        upstream_model_i.shift(1'b0, 1'b1);
        #1;
        cmp({7'h00, capture_ready}, 8'h00, "buffer full");
        upstream_model_i.shift(1'b1, 1'b1);
        #1;
        cmp(stage_q, 8'h0D, "shift while full");
        pop(8'h03);
        pop(8'h06);
        cmp({7'h00, word_valid}, 8'h00, "buffer empty");
        $display("test buffer done");
        final_report();
    end
endmodule
